// ==== klc_pkg.sv ====
//
// Functional notes
// - Any command error sets summary error flag
// - Error cause register holds individual cause flags
// - Memory key load: address low then high
// - Wait for both address bytes, then read memory
// - Memory key load ends by itself
// - Bad memory key: undefined key, key format error
// - Buffer key load: twelve bytes, byte 0 first
// - Wait twelve bytes, check encoding, load key
// - Buffer key load ends by itself
// - Bad buffer key: consume all, flag error
// - Auth step one sends six argument bytes
// - Auth step one reply kept internal
// - Auth steps use transceive sequence, host-started
// - Auth step two: no arguments, internal data
// - Auth step two success sets cipher bit
// - Auth step two failure clears cipher bit
// - Host may clear cipher bit, never set
package klc_pkg;
   // ****************************************
   // Register map (byte addresses)
   // ****************************************
   localparam logic [7:0] ADDR_CMD = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_ERROR = 8'h08;
   localparam logic [7:0] ADDR_CTRL = 8'h0c;
   // ****************************************
   // Opcodes
   // ****************************************
   localparam logic [7:0] OP_IDLE = 8'h00;
   localparam logic [7:0] OP_KEY_MEM = 8'h0b;
   localparam logic [7:0] OP_KEY_BUF = 8'h19;
   localparam logic [7:0] OP_AUTH1 = 8'h0c;
   localparam logic [7:0] OP_AUTH2 = 8'h14;
   // ****************************************
   // Field positions and counts
   // ****************************************
   localparam int ST_BUSY = 0;
   localparam int ST_ERR = 1;
   localparam int ST_CIPHER = 2;
   localparam int CTRL_CIPHER = 0;
   localparam logic [3:0] AUTH1_ARGS = 4'h6;
   localparam logic [3:0] MEM_ARGS = 4'h2;
   localparam logic [6:0] ERR_RESET = 7'h00;
   // Error cause register layout, bit 0 is key_format_error
   typedef struct packed {
      logic bit_collision_error;
      logic parity_bit_error;
      logic frame_error;
      logic checksum_error;
      logic buffer_overflow_error;
      logic memory_access_error;
      logic key_format_error;
   } klc_err_type;
   // Error events reported by neighbouring units
   typedef struct packed {
      logic memory_access;
      logic buffer_overflow;
      logic checksum;
      logic frame;
      logic parity;
      logic collision;
   } klc_evt_type;
   typedef enum logic [5:0] {
      S_IDLE = 6'b000001,
      S_ARGS = 6'b000010,
      S_MEMRD = 6'b000100,
      S_DECODE = 6'b001000,
      S_TX = 6'b010000,
      S_RX = 6'b100000
   } klc_state_type;
endpackage : klc_pkg

// ==== klc_top.sv ====
module klc_top #(
   parameter int KEY_BYTES = 12,
   parameter int AUTH2_LEN = 8,
   parameter int MEM_AW = 9
) (
   // APB
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // FIFO head
   input wire logic fifo_valid,
   input wire logic [7:0] fifo_data,
   output logic fifo_pop,
   // Nonvolatile memory read port
   output logic mem_rd,
   output logic [MEM_AW-1:0] mem_addr,
   input wire logic mem_rd_valid,
   input wire logic [7:0] mem_rd_data,
   // Card transceive link
   output logic card_tx_valid,
   output logic [7:0] card_tx_byte,
   output logic card_tx_last,
   input wire logic card_tx_ready,
   input wire logic card_rx_valid,
   input wire logic card_rx_done,
   input wire logic card_rx_ok,
   // Events and status
   input wire klc_pkg::klc_evt_type err_evt,
   output logic cipher_active_bit,
   output logic err_summary,
   output logic [KEY_BYTES*4-1:0] key_out
);
   // ****************************************
   // Elaboration check
   // ****************************************
   if (KEY_BYTES % 2 != 0 || KEY_BYTES > 15 || AUTH2_LEN < 1 || AUTH2_LEN > KEY_BYTES
       || MEM_AW < 9 || MEM_AW > 16) begin : g_bad
      $error("klc_top: unsupported parameter values");
   end
   localparam logic [3:0] KEY_N = 4'(KEY_BYTES);
   localparam logic [3:0] A2_N = 4'(AUTH2_LEN);

   // Each byte carries a nibble with its complement above it
   function automatic logic [8:0] decode_pair(input logic [7:0] lo_b, input logic [7:0] hi_b);
      logic bad;
      bad = (lo_b[7:4] != ~lo_b[3:0]) || (hi_b[7:4] != ~hi_b[3:0]);
      return {bad, hi_b[3:0], lo_b[3:0]};
   endfunction : decode_pair

   function automatic logic is_cmd(input logic [7:0] op);
      return op == klc_pkg::OP_KEY_MEM || op == klc_pkg::OP_KEY_BUF
         || op == klc_pkg::OP_AUTH1 || op == klc_pkg::OP_AUTH2;
   endfunction : is_cmd

   // ****************************************
   // State
   // ****************************************
   klc_pkg::klc_state_type state_ff, nxt_state;
   klc_pkg::klc_err_type err_ff, nxt_err;
   logic [7:0] op_ff, nxt_op;
   logic [3:0] cnt_ff, nxt_cnt;
   logic [7:0] enc_ff [KEY_BYTES], nxt_enc [KEY_BYTES];
   logic [KEY_BYTES*4-1:0] key_ff, nxt_key;
   logic [15:0] addr_ff, nxt_addr;
   logic cipher_ff, nxt_cipher;
   logic pop_ff, nxt_pop;
   logic mrd_ff, nxt_mrd, mpend_ff, nxt_mpend;
   logic txv_ff, nxt_txv, txl_ff, nxt_txl;
   logic [7:0] txb_ff, nxt_txb;
   logic rdy_ff, nxt_rdy, slv_ff, nxt_slv, esum_ff, nxt_esum;
   logic [31:0] rd_ff, nxt_rd;
   logic decode_bad;
   logic [KEY_BYTES*4-1:0] decoded;
   logic wr_go, fifo_take;

   // Write takes effect at the access edge with pready high
   assign wr_go = psel && penable && rdy_ff && pwrite;
   // Pop is one cycle late, so never take a byte twice in a row
   assign fifo_take = fifo_valid && !pop_ff;

   // Single pass over the key byte pairs
   always_comb begin
      logic [8:0] pr;
      pr = '0;
      decode_bad = 1'b0;
      decoded = '0;
      for (int i = 0; i < KEY_BYTES / 2; i++) begin
         pr = decode_pair(enc_ff[2*i], enc_ff[2*i+1]);
         decoded[i*8 +: 8] = pr[7:0];
         decode_bad = decode_bad | pr[8];
      end
   end

   // ****************************************
   // Command sequencer
   // ****************************************
   always_comb begin
      nxt_state = state_ff;
      nxt_err = err_ff;
      nxt_op = op_ff;
      nxt_cnt = cnt_ff;
      nxt_enc = enc_ff;
      nxt_key = key_ff;
      nxt_addr = addr_ff;
      nxt_cipher = cipher_ff;
      nxt_pop = 1'b0;
      nxt_mrd = 1'b0;
      nxt_mpend = mpend_ff;
      nxt_txv = txv_ff;
      nxt_txl = txl_ff;
      nxt_txb = txb_ff;
      // Host may clear the cipher bit but never set it
      if (wr_go && paddr == klc_pkg::ADDR_CTRL && !pwdata[klc_pkg::CTRL_CIPHER])
         nxt_cipher = 1'b0;
      // Write-one-to-clear of error causes
      if (wr_go && paddr == klc_pkg::ADDR_ERROR)
         nxt_err = err_ff & ~klc_pkg::klc_err_type'(pwdata[6:0]);
      unique case (state_ff)
         klc_pkg::S_IDLE: begin
            // Only a host write starts a command
            if (wr_go && paddr == klc_pkg::ADDR_CMD && is_cmd(pwdata[7:0])) begin
               nxt_op = pwdata[7:0];
               nxt_cnt = '0;
               nxt_err = klc_pkg::klc_err_type'(klc_pkg::ERR_RESET);
               nxt_state = (pwdata[7:0] == klc_pkg::OP_AUTH1
                  || pwdata[7:0] == klc_pkg::OP_AUTH2) ? klc_pkg::S_TX : klc_pkg::S_ARGS;
            end
         end
         klc_pkg::S_ARGS: begin
            if (fifo_take) begin
               nxt_pop = 1'b1;
               nxt_cnt = cnt_ff + 4'h1;
               if (op_ff == klc_pkg::OP_KEY_MEM) begin
                  // Address low byte first, then high
                  if (cnt_ff == 4'h0)
                     nxt_addr[7:0] = fifo_data;
                  else
                     nxt_addr[15:8] = fifo_data;
                  // Both bytes present: start reading memory
                  if (cnt_ff == klc_pkg::MEM_ARGS - 4'h1) begin
                     nxt_cnt = '0;
                     nxt_state = klc_pkg::S_MEMRD;
                  end
               end else begin
                  // Byte 0 is least significant
                  nxt_enc[cnt_ff] = fifo_data;
                  // All twelve consumed even if badly encoded
                  if (cnt_ff == KEY_N - 4'h1)
                     nxt_state = klc_pkg::S_DECODE;
               end
            end
         end
         klc_pkg::S_MEMRD: begin
            // One outstanding memory read at a time
            if (!mpend_ff) begin
               nxt_mrd = 1'b1;
               nxt_mpend = 1'b1;
            end else if (mem_rd_valid) begin
               nxt_mpend = 1'b0;
               nxt_addr = addr_ff + 16'h0001;
               nxt_enc[cnt_ff] = mem_rd_data;
               nxt_cnt = cnt_ff + 4'h1;
               if (cnt_ff == KEY_N - 4'h1)
                  nxt_state = klc_pkg::S_DECODE;
            end
         end
         klc_pkg::S_DECODE: begin
            // Undefined key on bad encoding plus key format error
            nxt_key = decoded;
            if (decode_bad)
               nxt_err.key_format_error = 1'b1;
            // Ends on its own, no stop command
            nxt_state = klc_pkg::S_IDLE;
            nxt_op = klc_pkg::OP_IDLE;
         end
         klc_pkg::S_TX: begin
            if (txv_ff) begin
               if (card_tx_ready) begin
                  nxt_txv = 1'b0;
                  nxt_cnt = cnt_ff + 4'h1;
                  if (txl_ff)
                     nxt_state = klc_pkg::S_RX;
               end
            end else if (op_ff == klc_pkg::OP_AUTH1) begin
               // Six FIFO bytes go out in order
               if (fifo_take) begin
                  nxt_pop = 1'b1;
                  nxt_txv = 1'b1;
                  nxt_txb = fifo_data;
                  nxt_txl = (cnt_ff == klc_pkg::AUTH1_ARGS - 4'h1);
               end
            end else begin
               // Step two data from the key, zero past its end, FIFO untouched
               nxt_txv = 1'b1;
               nxt_txb = (cnt_ff < KEY_N / 4'h2) ? key_ff[cnt_ff*8 +: 8] : 8'h00;
               nxt_txl = (cnt_ff == A2_N - 4'h1);
            end
         end
         klc_pkg::S_RX: begin
            // Reply is absorbed here, nothing goes to the FIFO
            if (card_rx_done) begin
               if (op_ff == klc_pkg::OP_AUTH2)
                  nxt_cipher = card_rx_ok;
               nxt_state = klc_pkg::S_IDLE;
               nxt_op = klc_pkg::OP_IDLE;
            end
         end
      endcase
      // Hardware events win over any clear in the same cycle
      nxt_err.memory_access_error |= err_evt.memory_access;
      nxt_err.buffer_overflow_error |= err_evt.buffer_overflow;
      nxt_err.checksum_error |= err_evt.checksum;
      nxt_err.frame_error |= err_evt.frame;
      nxt_err.parity_bit_error |= err_evt.parity;
      nxt_err.bit_collision_error |= err_evt.collision;
      // Summary follows the cause register
      nxt_esum = |nxt_err;
   end

   // ****************************************
   // APB slave, no wait states
   // ****************************************
   always_comb begin
      nxt_rdy = psel && !penable && !rdy_ff;
      nxt_slv = 1'b0;
      nxt_rd = '0;
      if (psel && !penable) begin
         unique case (paddr)
            klc_pkg::ADDR_CMD: nxt_rd = {24'h000000, op_ff};
            klc_pkg::ADDR_STATUS: nxt_rd = {29'h0, cipher_ff, esum_ff, !state_ff[0]};
            klc_pkg::ADDR_ERROR: nxt_rd = {25'h0, err_ff};
            klc_pkg::ADDR_CTRL: nxt_rd = {31'h0, cipher_ff};
            default: nxt_slv = 1'b1;
         endcase
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= klc_pkg::S_IDLE;
         err_ff <= klc_pkg::klc_err_type'(klc_pkg::ERR_RESET);
         op_ff <= klc_pkg::OP_IDLE;
         cnt_ff <= '0;
         enc_ff <= '{default: 8'h00};
         key_ff <= '0;
         addr_ff <= '0;
         cipher_ff <= 1'b0;
         pop_ff <= 1'b0;
         mrd_ff <= 1'b0;
         mpend_ff <= 1'b0;
         txv_ff <= 1'b0;
         txl_ff <= 1'b0;
         txb_ff <= '0;
         rdy_ff <= 1'b0;
         slv_ff <= 1'b0;
         esum_ff <= 1'b0;
         rd_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         err_ff <= nxt_err;
         op_ff <= nxt_op;
         cnt_ff <= nxt_cnt;
         enc_ff <= nxt_enc;
         key_ff <= nxt_key;
         addr_ff <= nxt_addr;
         cipher_ff <= nxt_cipher;
         pop_ff <= nxt_pop;
         mrd_ff <= nxt_mrd;
         mpend_ff <= nxt_mpend;
         txv_ff <= nxt_txv;
         txl_ff <= nxt_txl;
         txb_ff <= nxt_txb;
         rdy_ff <= nxt_rdy;
         slv_ff <= nxt_slv;
         esum_ff <= nxt_esum;
         rd_ff <= nxt_rd;
      end
   end

   // Outputs straight from flops; address wraps in the memory size
   assign prdata = rd_ff;
   assign pready = rdy_ff;
   assign pslverr = slv_ff;
   assign fifo_pop = pop_ff;
   assign mem_rd = mrd_ff;
   assign mem_addr = MEM_AW'(addr_ff);
   assign card_tx_valid = txv_ff;
   assign card_tx_byte = txb_ff;
   assign card_tx_last = txl_ff;
   assign cipher_active_bit = cipher_ff;
   assign err_summary = esum_ff;
   assign key_out = key_ff;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_ERR_SUM: assert property (err_summary == |err_ff)
      else $error("summary error flag disagrees with cause register");
   AST_EVT_STICKY: assert property (err_evt.checksum |=> err_ff.checksum_error)
      else $error("checksum event lost");
   AST_ADDR_ORDER: assert property (state_ff == klc_pkg::S_MEMRD && !mpend_ff && cnt_ff == 4'h0
      |=> mem_rd && mem_addr == MEM_AW'($past(addr_ff)))
      else $error("first memory read not at argument address");
   AST_MEM_NO_POP: assert property (state_ff == klc_pkg::S_MEMRD |=> !fifo_pop)
      else $error("FIFO popped during memory key read");
   AST_AUTO_END: assert property (state_ff == klc_pkg::S_DECODE
      |=> state_ff == klc_pkg::S_IDLE && op_ff == klc_pkg::OP_IDLE)
      else $error("key load did not end by itself");
   AST_KEY_ERR: assert property (state_ff == klc_pkg::S_DECODE && decode_bad
      |=> err_ff.key_format_error)
      else $error("bad key encoding not flagged");
   AST_TX_HOLD: assert property (card_tx_valid && !card_tx_ready
      |=> card_tx_valid && $stable(card_tx_byte))
      else $error("card byte dropped before accept");
   AST_AUTH2_NO_FIFO: assert property (op_ff == klc_pkg::OP_AUTH2 |-> ##1 !fifo_pop)
      else $error("step two touched the FIFO");
   AST_CIPHER_SET: assert property ($rose(cipher_active_bit) |-> $past(state_ff
      == klc_pkg::S_RX && op_ff == klc_pkg::OP_AUTH2 && card_rx_done && card_rx_ok))
      else $error("cipher bit set without successful step two");
   AST_CIPHER_FAIL: assert property (state_ff == klc_pkg::S_RX && op_ff == klc_pkg::OP_AUTH2
      && card_rx_done && !card_rx_ok |=> !cipher_active_bit)
      else $error("cipher bit not cleared on failed step two");

   COV_BUF_LOAD: cover property (state_ff == klc_pkg::S_DECODE && op_ff == klc_pkg::OP_KEY_BUF);
   COV_MEM_LOAD: cover property (state_ff == klc_pkg::S_DECODE && op_ff == klc_pkg::OP_KEY_MEM);
   COV_AUTH_OK: cover property ($rose(cipher_active_bit));
endmodule : klc_top

// ==== klc_far_model.sv ====
module klc_far_model (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Scenario controls
   input wire logic slow,
   input wire logic card_ok,
   // FIFO head
   output logic fifo_valid,
   output logic [7:0] fifo_data,
   input wire logic fifo_pop,
   // Memory read port
   input wire logic mem_rd,
   input wire logic [8:0] mem_addr,
   output logic mem_rd_valid,
   output logic [7:0] mem_rd_data,
   // Card link
   input wire logic card_tx_valid,
   input wire logic [7:0] card_tx_byte,
   input wire logic card_tx_last,
   output logic card_tx_ready,
   output logic card_rx_valid,
   output logic card_rx_done,
   output logic card_rx_ok
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] q[$];
   logic [8:0] tx_q[$];
   logic [7:0] mem [512];
   int reply_cnt;

   // Host side loads a byte; the head follows one edge later
   task automatic push_byte(input logic [7:0] b);
      q.push_back(b);
   endtask : push_byte

   // ****************************************
   // FIFO head and memory
   // ****************************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fifo_valid <= 1'b0;
         fifo_data <= 8'ha5;
         mem_rd_valid <= 1'b0;
         mem_rd_data <= 8'h5a;
      end else begin
         if (fifo_pop && q.size() != 0) begin
            void'(q.pop_front());
         end
         fifo_valid <= (q.size() != 0);
         // Empty head toggles so a stale byte can never pass for data
         fifo_data <= (q.size() != 0) ? q[0] : ~fifo_data;
         mem_rd_valid <= mem_rd;
         mem_rd_data <= mem_rd ? mem[mem_addr] : ~mem_rd_data;
      end
   end

   // ****************************************
   // Card
   // ****************************************
   // A slow card accepts only every other cycle; reply ends 4 cycles on
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         card_tx_ready <= 1'b0;
         card_rx_valid <= 1'b0;
         card_rx_done <= 1'b0;
         card_rx_ok <= 1'b0;
         reply_cnt <= 0;
      end else begin
         card_tx_ready <= slow ? ~card_tx_ready : 1'b1;
         if (card_tx_valid && card_tx_ready) begin
            tx_q.push_back({card_tx_last, card_tx_byte});
            if (card_tx_last) reply_cnt <= 4;
         end else if (reply_cnt != 0) begin
            reply_cnt <= reply_cnt - 1;
         end
         card_rx_valid <= (reply_cnt > 1);
         card_rx_done <= (reply_cnt == 1);
         // Outcome only means something beside done
         card_rx_ok <= (reply_cnt == 1) ? card_ok : ~card_rx_ok;
      end
   end
endmodule : klc_far_model

// ==== testbench.sv ====
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slow, card_ok;
   logic [7:0] paddr, fifo_data, mem_rd_data, card_tx_byte;
   logic [31:0] pwdata, prdata, rd;
   logic fifo_valid, fifo_pop, mem_rd, mem_rd_valid, card_tx_valid, card_tx_last;
   logic card_tx_ready, card_rx_valid, card_rx_done, card_rx_ok, rd_err;
   logic cipher_active_bit, err_summary;
   logic [8:0] mem_addr;
   logic [47:0] key_out;
   klc_pkg::klc_evt_type err_evt;
   int err_total = 0;
   int total_checks = 0;

   klc_top #(.KEY_BYTES(12), .AUTH2_LEN(8), .MEM_AW(9)) dut (.pclk, .presetn, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .fifo_valid,
      .fifo_data, .fifo_pop, .mem_rd, .mem_addr, .mem_rd_valid, .mem_rd_data,
      .card_tx_valid, .card_tx_byte, .card_tx_last, .card_tx_ready, .card_rx_valid,
      .card_rx_done, .card_rx_ok, .err_evt, .cipher_active_bit, .err_summary, .key_out);
   klc_far_model far (.pclk, .presetn, .slow, .card_ok, .fifo_valid, .fifo_data,
      .fifo_pop, .mem_rd, .mem_addr, .mem_rd_valid, .mem_rd_data, .card_tx_valid,
      .card_tx_byte, .card_tx_last, .card_tx_ready, .card_rx_valid, .card_rx_done,
      .card_rx_ok);

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic check(input logic [47:0] seen, input logic [47:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   // One APB transfer; waits for pready with a bound, then lets updates land
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      rd_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      check(48'(n < 50), 48'h1);
      #1;
   endtask : apb

   task automatic wait_idle();
      int n;
      n = 0;
      do begin
         apb(1'b0, klc_pkg::ADDR_STATUS, 32'h0);
         n++;
      end while (rd[klc_pkg::ST_BUSY] !== 1'b0 && n < 100);
      check(48'(rd[klc_pkg::ST_BUSY]), 48'h0);
   endtask : wait_idle

   // Error cause register must hold exactly the key format flag or nothing
   task automatic check_key_format_error(input logic bad);
      check(48'(err_summary), 48'(bad));
      apb(1'b0, klc_pkg::ADDR_ERROR, 32'h0);
      check(48'(rd), 48'(bad));
   endtask : check_key_format_error

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_key_buf(input logic [47:0] k, input logic bad);
      logic [3:0] nb;
      for (int i = 0; i < 12; i++) begin
         nb = k[4*i +: 4];
         far.push_byte({~nb ^ {3'h0, bad && i == 5}, nb});
      end
      apb(1'b1, klc_pkg::ADDR_CMD, {24'h0, klc_pkg::OP_KEY_BUF});
      wait_idle();
      if (!bad) check(key_out, k);
      check(48'(far.q.size()), 48'h0);
      check_key_format_error(bad);
   endtask : t_key_buf

   // Start address is an argument; 9'h1fa near the top makes the key wrap around the memory
   task automatic t_key_mem(input logic [8:0] a, input logic [47:0] k, input logic bad);
      logic [3:0] nb;
      for (int i = 0; i < 12; i++) begin
         nb = k[4*i +: 4];
         far.mem[9'(a + i)] = {~nb ^ {3'h0, bad && i == 0}, nb};
      end
      far.push_byte(a[7:0]);
      far.push_byte({7'h0, a[8]});
      apb(1'b1, klc_pkg::ADDR_CMD, {24'h0, klc_pkg::OP_KEY_MEM});
      wait_idle();
      if (!bad) check(key_out, k);
      check_key_format_error(bad);
   endtask : t_key_mem

   task automatic t_auth(input logic ok);
      logic [7:0] arg[6] = '{8'h60, 8'h07, 8'h11, 8'h22, 8'h33, 8'h44};
      logic c0;
      c0 = cipher_active_bit;
      far.tx_q.delete();
      card_ok <= ok;
      foreach (arg[i]) far.push_byte(arg[i]);
      apb(1'b1, klc_pkg::ADDR_CMD, {24'h0, klc_pkg::OP_AUTH1});
      wait_idle();
      check(48'(far.tx_q.size()), 48'h6);
      foreach (arg[i]) check(48'(far.tx_q[i]), 48'({i == 5, arg[i]}));
      check(48'(cipher_active_bit), 48'(c0));
      far.tx_q.delete();
      far.push_byte(8'h5c);
      apb(1'b1, klc_pkg::ADDR_CMD, {24'h0, klc_pkg::OP_AUTH2});
      wait_idle();
      check(48'(far.q.size()), 48'h1);
      check(48'(far.tx_q.size()), 48'h8);
      check(48'(far.tx_q[7][8]), 48'h1);
      check(48'(cipher_active_bit), 48'(ok));
      check(48'(rd[klc_pkg::ST_CIPHER]), 48'(ok));
      far.q.delete();
   endtask : t_auth

   task automatic t_ctrl();
      apb(1'b1, klc_pkg::ADDR_CTRL, 32'h1);
      check(48'(cipher_active_bit), 48'h1);
      apb(1'b1, klc_pkg::ADDR_CTRL, 32'h0);
      check(48'(cipher_active_bit), 48'h0);
      apb(1'b1, klc_pkg::ADDR_CTRL, 32'h1);
      check(48'(cipher_active_bit), 48'h0);
      // An opcode that is not a command must not leave the sequencer busy
      apb(1'b1, klc_pkg::ADDR_CMD, 32'h55);
      apb(1'b0, klc_pkg::ADDR_STATUS, 32'h0);
      check(48'(rd[klc_pkg::ST_BUSY]), 48'h0);
   endtask : t_ctrl

   // Every event source sets its own cause bit, then is cleared by writing one
   task automatic t_events();
      for (int j = 0; j < 6; j++) begin
         @(posedge pclk);
         err_evt <= klc_pkg::klc_evt_type'(6'h20 >> j);
         @(posedge pclk);
         err_evt <= '0;
         apb(1'b0, klc_pkg::ADDR_ERROR, 32'h0);
         check(48'(rd), 48'(2 << j));
         check(48'(err_summary), 48'h1);
         apb(1'b1, klc_pkg::ADDR_ERROR, 32'(2 << j));
         apb(1'b0, klc_pkg::ADDR_ERROR, 32'h0);
         check(48'(rd), 48'h0);
      end
      apb(1'b0, 8'h10, 32'h0);
      check(48'(rd_err), 48'h1);
   endtask : t_events

   task automatic tally_and_finish();
      $display("Checks %0d, errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : tally_and_finish

   // ****************************************
   // Clock, sequence and watchdog
   // ****************************************
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   initial begin
      {presetn, psel, penable, pwrite, slow, card_ok} = 6'h0;
      paddr = 8'h0;
      pwdata = 32'h0;
      err_evt = '0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      #1;
      check(key_out, 48'h0);
      t_key_buf(48'h0123456789ab, 1'b1);
      t_key_mem(9'h1fa, 48'h5a5a00ff1234, 1'b0);
      t_key_mem(9'h020, 48'h0, 1'b1);
      t_key_buf(48'ha1b2c3d4e5f6, 1'b0);
      t_auth(1'b1);
      t_ctrl();
      slow <= 1'b1;
      t_auth(1'b1);
      t_auth(1'b0);
      t_events();
      tally_and_finish();
   end

   // A hang counts as a mismatch
   initial begin
      #100000;
      err_total++;
      tally_and_finish();
   end
endmodule : testbench
